/* File: verilog/acr_regs.sv */
// channel-0 configuration register slice with threshold and current detect
// assumes a plain register port and conversions arriving as one-cycle pulses
//
// Decided for this implementation: the strobed register port.
`include "acr_map.svh"

module acr_regs (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    input  wire logic        conv_valid,
    input  wire logic [23:0] conv_data,
    output logic [23:0]      detect_threshold,
    output logic [3:0]       highpass_coeff_select,
    output logic [9:0]       chan0_phase_delay,
    output logic             chan0_highpass_off,
    output logic [1:0]       chan0_input_select,
    output logic [23:0]      chan0_offset,
    output logic [15:0]      chan0_gain_upper,
    output logic             filt_valid,
    output logic [23:0]      filt_data,
    output logic             detect_hit
);

    acr_pkg::acr_state_t s_q;
    acr_pkg::acr_state_t s_d;
    logic signed [23:0]  f_d;
    logic                f_v;
    logic                exceed;
    logic [7:0]          target;
    logic                wr_any;
    logic                gain_wr_q;

    // magnitude of a signed result; the most negative value still fits unsigned
    function automatic logic [23:0] mag(input logic signed [23:0] v);
        return v[23] ? 24'(-v) : v;
    endfunction

    function automatic logic hit_addr(input logic [3:0] a, input logic [3:0] b);
        return a == b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register writes, read mux and detection counter
    always_comb begin
        s_d     = s_q;
        wr_any  = reg_wr;
        exceed  = f_v && mag(f_d) > {s_q.th_hi, s_q.th_lo};
        target  = `ACR_CNT_ONE << s_q.det_num;
        s_d.rdata  = `ACR_RST_ZERO;
        s_d.conv_v = conv_valid;
        // offset is stored as the value to take away from each raw result
        s_d.conv_d = conv_data - {s_q.ocal_hi, s_q.ocal_lo};

        if (wr_any) begin
            case (reg_addr)
                `ACR_ADDR_TH_HI: begin
                    s_d.th_hi = reg_wdata[`ACR_F_WORD];
                end
                `ACR_ADDR_TH_LO: begin
                    s_d.th_lo = reg_wdata[`ACR_F_TH_LO];
                    s_d.coeff = reg_wdata[`ACR_F_COEFF];
                end
                `ACR_ADDR_CHANNEL0_CONFIG: begin
                    s_d.phase  = reg_wdata[`ACR_F_PHASE];
                    s_d.hp_off = reg_wdata[`ACR_B_HP_OFF];
                    s_d.insel  = reg_wdata[`ACR_F_INSEL];
                end
                `ACR_ADDR_OCAL_HI: begin
                    s_d.ocal_hi = reg_wdata[`ACR_F_WORD];
                end
                `ACR_ADDR_OCAL_LO: begin
                    s_d.ocal_lo = reg_wdata[`ACR_F_OCAL_LO];
                end
                `ACR_ADDR_GAIN_HI: begin
                    s_d.gain_hi = reg_wdata[`ACR_F_WORD];
                end
                `ACR_ADDR_DET: begin
                    s_d.det_en  = reg_wdata[`ACR_B_DET_EN];
                    s_d.det_num = reg_wdata[`ACR_F_DET_NUM];
                    s_d.det_cnt = `ACR_ZERO_BYTE;
                    if (reg_wdata[`ACR_B_DET_HIT]) begin
                        s_d.det_hit = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // placed after the clear so a detection in the same cycle is kept
        if (s_q.det_en && exceed) begin
            if (s_q.det_cnt + `ACR_CNT_ONE >= target) begin
                s_d.det_hit = 1'b1;
                s_d.det_cnt = `ACR_ZERO_BYTE;
            end else begin
                s_d.det_cnt = s_q.det_cnt + `ACR_CNT_ONE;
            end
        end

        if (reg_rd) begin
            case (reg_addr)
                `ACR_ADDR_TH_HI:   s_d.rdata = s_q.th_hi;
                `ACR_ADDR_TH_LO:   s_d.rdata = {s_q.th_lo, 4'h0, s_q.coeff};
                `ACR_ADDR_CHANNEL0_CONFIG: s_d.rdata = {s_q.phase, 3'h0, s_q.hp_off, s_q.insel};
                `ACR_ADDR_OCAL_HI: s_d.rdata = s_q.ocal_hi;
                `ACR_ADDR_OCAL_LO: s_d.rdata = {s_q.ocal_lo, `ACR_ZERO_BYTE};
                `ACR_ADDR_GAIN_HI: s_d.rdata = s_q.gain_hi;
                `ACR_ADDR_DET: s_d.rdata = {s_q.det_hit, 7'h00, 1'b0, s_q.det_num,
                                            3'h0, s_q.det_en};
                default:           s_d.rdata = `ACR_RST_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q         <= '0;
            s_q.gain_hi <= `ACR_RST_GAIN;
        end else begin
            s_q <= s_d;
        end
    end

    // assertion helper: set once software has written the gain word
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gain_wr_q <= 1'b0;
        end else if (reg_wr && hit_addr(reg_addr, `ACR_ADDR_GAIN_HI)) begin
            gain_wr_q <= 1'b1;
        end
    end

    acr_hpf u_hpf (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .in_v    (s_q.conv_v),
        .in_d    (s_q.conv_d),
        .coeff   (s_q.coeff),
        .bypass  (s_q.hp_off),
        .out_v   (f_v),
        .out_d   (f_d)
    );

    assign reg_rdata             = s_q.rdata;
    assign detect_threshold      = {s_q.th_hi, s_q.th_lo};
    assign highpass_coeff_select = s_q.coeff;
    assign chan0_phase_delay     = s_q.phase;
    assign chan0_highpass_off    = s_q.hp_off;
    assign chan0_input_select    = s_q.insel;
    assign chan0_offset          = {s_q.ocal_hi, s_q.ocal_lo};
    assign chan0_gain_upper      = s_q.gain_hi;
    assign filt_valid            = f_v;
    assign filt_data             = f_d;
    assign detect_hit            = s_q.det_hit;

    ////////////////////////////////////////////////////////////////////////////
    th_hi_wr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == `ACR_ADDR_TH_HI
        |=> detect_threshold[23:8] == $past(reg_wdata))
        else $error("threshold upper word not stored");

    th_lo_wr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == `ACR_ADDR_TH_LO
        |=> detect_threshold[7:0] == $past(reg_wdata[15:8]))
        else $error("threshold lower byte not stored");

    coeff_wr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == `ACR_ADDR_TH_LO
        |=> highpass_coeff_select == $past(reg_wdata[3:0]))
        else $error("coefficient select not stored");

    lo_rsvd_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_rd && reg_addr == `ACR_ADDR_TH_LO
        |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved threshold bits read nonzero");

    phase_wr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == `ACR_ADDR_CHANNEL0_CONFIG
        |=> chan0_phase_delay == $past(reg_wdata[15:6]))
        else $error("phase delay not stored");

    cfg_bits_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == `ACR_ADDR_CHANNEL0_CONFIG
        |=> chan0_highpass_off == $past(reg_wdata[2])
            && chan0_input_select == $past(reg_wdata[1:0]))
        else $error("channel config bits not stored");

    ocal_wr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == `ACR_ADDR_OCAL_HI
        |=> chan0_offset[23:8] == $past(reg_wdata))
        else $error("offset upper word not stored");

    ocal_rsvd_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_rd && reg_addr == `ACR_ADDR_OCAL_LO
        |=> reg_rdata == {chan0_offset[7:0], 8'h00})
        else $error("offset lower register read wrong");

    gain_rst_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !gain_wr_q |-> chan0_gain_upper == 16'h8000)
        else $error("gain word lost its reset value");

    gain_rd_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == `ACR_ADDR_GAIN_HI ##1 reg_rd && reg_addr == `ACR_ADDR_GAIN_HI
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("gain word read back wrong");

    det_cause_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(detect_hit) |-> $past(exceed && s_q.det_en))
        else $error("detection without threshold exceed");

    det_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_q.det_en && s_q.det_num == 3'h0 && exceed |=> detect_hit)
        else $error("single exceed did not detect");

    // looked at one edge later: the first edge may be the one that applies reset
    rst_zero_a: assert property (@(posedge sys_clk)
        !nrst |=> detect_threshold == 24'h0 && chan0_offset == 24'h0
                  && chan0_phase_delay == 10'h0)
        else $error("registers not zero in reset");

    det_c: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(detect_hit));
    off_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        f_v && chan0_highpass_off);
    rd_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr ##1 reg_rd);

endmodule

/* File: shared/acr_map.svh */
// register offsets, field positions and reset values of the channel config slice
// assumes a 4-bit word address on the plain register port
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

`define ACR_ADDR_TH_HI   4'h7
`define ACR_ADDR_TH_LO   4'h8
`define ACR_ADDR_CHANNEL0_CONFIG 4'h9
`define ACR_ADDR_OCAL_HI 4'hA
`define ACR_ADDR_OCAL_LO 4'hB
`define ACR_ADDR_GAIN_HI 4'hC
`define ACR_ADDR_DET     4'hF

`define ACR_F_WORD    15:0
`define ACR_F_TH_LO   15:8
`define ACR_F_COEFF   3:0
`define ACR_F_PHASE   15:6
`define ACR_B_HP_OFF  2
`define ACR_F_INSEL   1:0
`define ACR_F_OCAL_LO 15:8
`define ACR_F_DET_NUM 6:4
`define ACR_B_DET_EN  0
`define ACR_B_DET_HIT 15

`define ACR_RST_ZERO  16'h0000
`define ACR_RST_GAIN  16'h8000
`define ACR_ZERO_BYTE 8'h00
`define ACR_CNT_ONE   8'h01
`define ACR_SHIFT_ONE 5'h01

`endif

/* File: shared/acr_pkg.sv */
// types shared by the register slice and its high-pass filter
// assumes acr_map.svh is on the include path
package acr_pkg;

    typedef struct packed {
        logic [15:0] th_hi;
        logic [7:0]  th_lo;
        logic [3:0]  coeff;
        logic [9:0]  phase;
        logic        hp_off;
        logic [1:0]  insel;
        logic [15:0] ocal_hi;
        logic [7:0]  ocal_lo;
        logic [15:0] gain_hi;
        logic        det_en;
        logic [2:0]  det_num;
        logic [7:0]  det_cnt;
        logic        det_hit;
        logic [15:0] rdata;
        logic        conv_v;
        logic [23:0] conv_d;
    } acr_state_t;

    typedef struct packed {
        logic               out_v;
        logic signed [23:0] out_d;
        logic signed [23:0] x_prev;
        logic signed [25:0] y_prev;
    } acr_hpf_state_t;

    // code 1 gives 1/4, each step halves: shift = code + 1
    function automatic logic [4:0] coeff_shift(input logic [3:0] code);
        return {1'b0, code} + 5'h01;
    endfunction

endpackage

/* File: verilog/acr_hpf.sv */
// first-order dc-block high-pass on the offset-corrected conversion stream
// assumes one result per in_v pulse; coefficient may change between results
`include "acr_map.svh"

module acr_hpf (
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic               in_v,
    input  wire logic signed [23:0] in_d,
    input  wire logic [3:0]         coeff,
    input  wire logic               bypass,
    output logic                    out_v,
    output logic signed [23:0]      out_d
);

    acr_pkg::acr_hpf_state_t s_q;
    acr_pkg::acr_hpf_state_t s_d;
    logic signed [25:0]      y;
    logic [4:0]              sh;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d   = s_q;
        sh    = acr_pkg::coeff_shift(coeff);
        y     = 26'(in_d) - 26'(s_q.x_prev) + s_q.y_prev - (s_q.y_prev >>> sh);
        s_d.out_v = in_v;
        if (in_v) begin
            if (bypass || coeff == 4'h0) begin
                // history restarts so re-enabling gives no step
                s_d.out_d  = in_d;
                s_d.y_prev = 26'sh0;
            end else begin
                s_d.y_prev = y;
                if (y > 26'sh07FFFFF) begin
                    s_d.out_d = 24'sh7FFFFF;
                end else if (y < -26'sh0800000) begin
                    s_d.out_d = -24'sh800000;
                end else begin
                    s_d.out_d = y[23:0];
                end
            end
            s_d.x_prev = in_d;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign out_v = s_q.out_v;
    assign out_d = s_q.out_d;

    ////////////////////////////////////////////////////////////////////////////
    hp_pass_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_v && (bypass || coeff == 4'h0) |=> out_v && out_d == $past(in_d))
        else $error("filter off but result altered");

    hp_dc_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_v && !bypass && coeff != 4'h0 && in_d == s_q.x_prev && s_q.y_prev == 26'sh0
        |=> out_d == 24'sh0)
        else $error("high-pass passed a constant input");

    hp_on_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        in_v && !bypass && coeff == 4'hF);

endmodule

/* File: testbench/acr_regs_tb_top.sv */
// self-checking bench for the channel-0 register slice, filter path and detection
// assumes acr_map.svh on the include path; bench drives every input port itself
`include "acr_map.svh"

module acr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk;
    logic        nrst;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        conv_valid;
    logic [23:0] conv_data;
    logic [23:0] detect_threshold;
    logic [3:0]  highpass_coeff_select;
    logic [9:0]  chan0_phase_delay;
    logic        chan0_highpass_off;
    logic [1:0]  chan0_input_select;
    logic [23:0] chan0_offset;
    logic [15:0] chan0_gain_upper;
    logic        filt_valid;
    logic [23:0] filt_data;
    logic        detect_hit;
    int          n_errors;
    int          checks;
    int          cyc;

    acr_regs acr_regs_i (
        .sys_clk               (sys_clk),
        .nrst                  (nrst),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .conv_valid            (conv_valid),
        .conv_data             (conv_data),
        .detect_threshold      (detect_threshold),
        .highpass_coeff_select (highpass_coeff_select),
        .chan0_phase_delay     (chan0_phase_delay),
        .chan0_highpass_off    (chan0_highpass_off),
        .chan0_input_select    (chan0_input_select),
        .chan0_offset          (chan0_offset),
        .chan0_gain_upper      (chan0_gain_upper),
        .filt_valid            (filt_valid),
        .filt_data             (filt_data),
        .detect_hit            (detect_hit)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // no scenario needs more than a few hundred cycles, so a hang shows up quickly
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe, so it is sampled there
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata", 24'(reg_rdata), 24'(exp));
    endtask

    // write then read with no idle cycle between the two strobes
    task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge sys_clk);
        reg_rd    <= 1'b0;
        #1;
        chk("reg_rdata", 24'(reg_rdata), 24'(d));
        chk("gain_out", 24'(chan0_gain_upper), 24'(d));
    endtask

    task automatic conv(input logic [23:0] x, input logic [23:0] exp);
        @(posedge sys_clk);
        conv_valid <= 1'b1;
        conv_data  <= x;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("filt_valid", 24'(filt_valid), 24'h000001);
        chk("filt_data", filt_data, exp);
    endtask

    task automatic conv_hit(input logic [23:0] x, input logic hit);
        conv(x, x);
        @(posedge sys_clk);
        #1;
        chk("detect_hit", 24'(detect_hit), 24'(hit));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        #1;
        chk("gain_out", 24'(chan0_gain_upper), 24'h008000);
        chk("thresh_out", detect_threshold, 24'h000000);
        for (int a = 7; a <= 12; a++)
            rd_chk(4'(a), (a == 12) ? `ACR_RST_GAIN : `ACR_RST_ZERO);
    endtask

    // fresh history after reset: steady input decays by a quarter per result
    task automatic test_filter_on();
        wr(`ACR_ADDR_TH_LO, 16'h0001);
        conv(24'h000400, 24'h000400);
        conv(24'h000400, 24'h000300);
        conv(24'h000400, 24'h000240);
    endtask

    task automatic test_fields();
        logic [15:0] mask [6];
        mask = '{16'hFFFF, 16'hFF0F, 16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF};
        for (int a = 7; a <= 12; a++)
            wr(4'(a), 16'hFFFF);
        wr(4'h3, 16'hFFFF);
        for (int a = 7; a <= 12; a++)
            rd_chk(4'(a), mask[a - 7]);
        rd_chk(4'h3, 16'h0000);
        chk("thresh_out", detect_threshold, 24'hFFFFFF);
        chk("offset_out", chan0_offset, 24'hFFFFFF);
        chk("coeff_out", 24'(highpass_coeff_select), 24'h00000F);
        chk("hp_off_out", 24'(chan0_highpass_off), 24'h000001);
        for (int c = 0; c < 4; c++) begin
            wr(`ACR_ADDR_CHANNEL0_CONFIG, 16'h8040 | 16'(c));
            chk("phase_out", 24'(chan0_phase_delay), 24'h000201);
            chk("insel_out", 24'(chan0_input_select), 24'(c));
            chk("hp_off_out", 24'(chan0_highpass_off), 24'h000000);
        end
        wr_rd(`ACR_ADDR_GAIN_HI, 16'h1234);
    endtask

    task automatic test_bypass();
        wr(`ACR_ADDR_OCAL_HI, 16'h0000);
        wr(`ACR_ADDR_OCAL_LO, 16'h1000);
        wr(`ACR_ADDR_TH_LO, 16'h0003);
        wr(`ACR_ADDR_CHANNEL0_CONFIG, 16'h0004);
        conv(24'h000005, 24'hFFFFF5);
        wr(`ACR_ADDR_CHANNEL0_CONFIG, 16'h0000);
        wr(`ACR_ADDR_TH_LO, 16'h0000);
        conv(24'h000020, 24'h000010);
        // same input again with the filter on and fresh history gives zero
        wr(`ACR_ADDR_TH_LO, 16'h000F);
        conv(24'h000020, 24'h000000);
        wr(`ACR_ADDR_TH_LO, 16'h0000);
    endtask

    task automatic test_detect();
        wr(`ACR_ADDR_OCAL_LO, 16'h0000);
        wr(`ACR_ADDR_TH_HI, 16'h0001);
        wr(`ACR_ADDR_DET, 16'h0011);
        conv_hit(24'h000100, 1'b0);
        conv_hit(24'h000200, 1'b0);
        conv_hit(24'hFFFE00, 1'b1);
        rd_chk(`ACR_ADDR_DET, 16'h8011);
        wr(`ACR_ADDR_DET, 16'h8011);
        chk("detect_hit", 24'(detect_hit), 24'h000000);
        conv_hit(24'h000300, 1'b0);
        wr(`ACR_ADDR_DET, 16'h0001);
        conv_hit(24'h000300, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        n_errors   = 0;
        checks     = 0;
        cyc        = 0;
        nrst       = 1'b0;
        reg_addr   = 4'h0;
        reg_wdata  = 16'h0000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        conv_valid = 1'b0;
        conv_data  = 24'h000000;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        test_reset();
        test_filter_on();
        test_fields();
        test_bypass();
        test_detect();
        summarize();
    end

endmodule
